/* File: include/sf_timing_pkg.sv */
// Function
// - After distant seizure, hold transmit cut 625 ms after received tone stops.
// - At seizure, remove receive notch filter 50 ms after received tone stops.
// - Lead ground to battery stops tone and cuts transmit path for 125 ms.
// - Lead battery to ground at start-dial resumes tone, cut held 625 ms.
// - Incoming dial pulses cut path at once, held 625 ms after last transition.
// - Notch inserted 13 ms after first pulse, held max(50 ms after last, 225 ms).
// - Tone returning in talking inserts notch after 13 ms, path stays uncut.
// - Local disconnect resumes tone, precuts path, then holds it cut into idle.
// - Signaling lead passes a symmetrical delay; shorter glitches never reach tone.
// - Transmit dialing breaks (tone intervals) are stretched to at least 50 ms.
// - Tone intervals longer than 50 ms pass unchanged.
// - Winks and momentary changes are not disturbed; only breaks get stretched.
// - The symmetrical lead delay is about 20 ms.
// - Lead change cuts transmit path at once; tone change follows the delay.
// - A-side uses M as input and E as output; B-side swaps them.
package sf_timing_pkg;

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS     = 1000000;
	localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Timer width in bits, then interval lengths in milliseconds (nominal centre of tolerance)
	// ----------------------------------------------------------------
	localparam int          TIMER_W           = 10;
	localparam logic [9:0]  SEIZE_CUT_MS      = 10'd625;
	localparam logic [9:0]  NOTCH_REMOVE_MS   = 10'd50;
	localparam logic [9:0]  ANSWER_CUT_MS     = 10'd125;
	localparam logic [9:0]  START_DIAL_CUT_MS = 10'd625;
	localparam logic [9:0]  DIAL_CUT_MS       = 10'd625;
	localparam logic [9:0]  NOTCH_INSERT_MS   = 10'd13;
	localparam logic [9:0]  NOTCH_MIN_MS      = 10'd225;
	localparam logic [9:0]  LEAD_DELAY_MS     = 10'd20;
	localparam logic [9:0]  MIN_BREAK_MS      = 10'd50;

	// ----------------------------------------------------------------
	// Call progress as seen by the timing logic
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SEIZE,
		ST_DIAL,
		ST_TALK
	} call_state_t;

endpackage : sf_timing_pkg

/* File: sim/sf_supervision_timing_props.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checker for cut, notch, gate and lead outputs
// ----------------------------------------------------------------
module sf_supervision_timing_props #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_side_b,
	input wire logic i_m_lead,
	input wire logic i_e_lead,
	input wire logic i_tone_rx,
	input wire logic o_tone_tx,
	input wire logic o_xmt_cut,
	input wire logic o_receive_notch_filter,
	input wire logic o_e_lead,
	input wire logic o_m_lead
);
	logic        lead;
	logic        lead_q;
	logic        tone_q;
	logic [31:0] since_lead;
	logic [31:0] since_tone;
	logic [31:0] since_rise;
	logic [31:0] since_gate;

	assign lead = i_side_b ? i_e_lead : i_m_lead;

	// Event age counters; they saturate so long idle spells never wrap
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lead_q     <= 1'b0;
			tone_q     <= 1'b1;
			since_lead <= '1;
			since_tone <= '1;
			since_rise <= '1;
			since_gate <= '1;
		end else begin
			lead_q     <= lead;
			tone_q     <= i_tone_rx;
			since_lead <= (lead != lead_q) ? 32'h0 : since_lead + {31'h0, ~&since_lead};
			since_tone <= (i_tone_rx != tone_q) ? 32'h0 : since_tone + {31'h0, ~&since_tone};
			since_rise <= (i_tone_rx & ~tone_q) ? 32'h0 : since_rise + {31'h0, ~&since_rise};
			since_gate <= $rose(o_tone_tx) ? 32'h0 : since_gate + {31'h0, ~&since_gate};
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	// Delay windows below assume the ten-cycle tick used in simulation
	AST_E_LEAD: assert property (!i_side_b |=> o_e_lead == !$past(i_tone_rx) && !o_m_lead)
		else $error("A-side output lead does not follow received tone");
	AST_M_LEAD: assert property (i_side_b |=> o_m_lead == !$past(i_tone_rx) && !o_e_lead)
		else $error("B-side output lead does not follow received tone");
	AST_CUT_TONE: assert property ($fell(o_xmt_cut) |-> since_tone >= 623 * TICK_CYCLES)
		else $error("Transmit cut released too soon after a tone edge");
	AST_CUT_LEAD: assert property ($fell(o_xmt_cut) |-> since_lead >= 123 * TICK_CYCLES)
		else $error("Transmit cut released too soon after a lead edge");
	AST_LEAD_CUT: assert property ($changed(lead) |-> ##[0:3] o_xmt_cut)
		else $error("Lead change did not cut the transmit path");
	AST_NOTCH_IN: assert property ($rose(i_tone_rx) && !o_receive_notch_filter
		|-> ##[115:145] o_receive_notch_filter)
		else $error("Notch not inserted after tone arrival");
	AST_NOTCH_EARLY: assert property ($rose(o_receive_notch_filter)
		|-> since_rise >= 11 * TICK_CYCLES)
		else $error("Notch inserted too early");
	AST_NOTCH_OUT: assert property ($fell(o_receive_notch_filter)
		|-> !i_tone_rx && since_tone >= 48 * TICK_CYCLES)
		else $error("Notch removed too early");
	AST_GATE: assert property ($rose(o_tone_tx)
		|-> !lead && since_lead >= 19 * TICK_CYCLES)
		else $error("Tone started before the lead settled");
	AST_MIN_BREAK: assert property ($fell(o_tone_tx) |-> since_gate >= 49 * TICK_CYCLES)
		else $error("Tone interval shorter than the minimum break");
endmodule : sf_supervision_timing_props

bind sf_supervision_timing sf_supervision_timing_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
	.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_side_b(i_side_b), .i_m_lead(i_m_lead),
	.i_e_lead(i_e_lead), .i_tone_rx(i_tone_rx), .o_tone_tx(o_tone_tx), .o_xmt_cut(o_xmt_cut),
	.o_receive_notch_filter(o_receive_notch_filter), .o_e_lead(o_e_lead), .o_m_lead(o_m_lead));

/* File: sim/sf_supervision_timing_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// Call sequence bench
// ----------------------------------------------------------------
module sf_supervision_timing_tb_top;
	localparam int T = 10;
	logic i_sys_clk = 1'b0;
	logic i_rst_b   = 1'b0;
	logic i_side_b  = 1'b0;
	logic i_tone_rx = 1'b1;
	logic busy      = 1'b0;
	logic tone_q    = 1'b1;
	logic i_m_lead, i_e_lead, o_tone_tx, o_xmt_cut, o_receive_notch_filter, o_e_lead, o_m_lead;
	int   num_errors  = 0;
	int   check_count = 0;
	int   cyc = 0;
	int   t0  = 0;
	int   w, last;
	int   falls[$];
	int   lens[3] = '{30, 80, 10};
	int   ext[3]  = '{50, 80, 0};

	always #5 i_sys_clk = ~i_sys_clk;

	sf_trunk_model u_sf_trunk_model (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_side_b(i_side_b), .i_busy(busy), .o_m_lead(i_m_lead), .o_e_lead(i_e_lead));

	sf_supervision_timing #(.TICK_CYCLES(T)) u_sf_supervision_timing (.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b), .i_side_b(i_side_b), .i_m_lead(i_m_lead), .i_e_lead(i_e_lead),
		.i_tone_rx(i_tone_rx), .o_tone_tx(o_tone_tx), .o_xmt_cut(o_xmt_cut),
		.o_receive_notch_filter(o_receive_notch_filter), .o_e_lead(o_e_lead), .o_m_lead(o_m_lead));

	task results;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// Cycle count, tone history and hang guard
	always @(posedge i_sys_clk) begin
		cyc    <= cyc + 1;
		tone_q <= i_tone_rx;
		if (cyc == 80000) begin
			num_errors++;
			results();
		end
	end

	// Output leads follow the received tone inverted, one clock late, every cycle out of reset
	always @(negedge i_sys_clk) begin
		if (i_rst_b) begin
			`CHK(o_e_lead, !i_side_b & !tone_q)
			`CHK(o_m_lead, i_side_b & !tone_q)
		end
	end

	function automatic logic get(input int s);
		case (s)
			0: return o_xmt_cut;
			1: return o_receive_notch_filter;
			2: return o_tone_tx;
			default: return o_xmt_cut | o_receive_notch_filter;
		endcase
	endfunction : get

	task wait_ms(input int n);
		repeat (n * T) @(posedge i_sys_clk);
	endtask : wait_ms

	// Time from the mark until the output reaches a level, within two ticks of slack
	task at(input int s, input logic v, input int exp_ms);
		int got;
		while (get(s) !== v && cyc - t0 < (exp_ms + 10) * T) @(negedge i_sys_clk);
		got = (cyc - t0 + T / 2) / T;
		`CHK(got >= exp_ms - 2 && got <= exp_ms + 2, 1'b1)
		@(posedge i_sys_clk);
	endtask : at

	task hold(input int s, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n * T) begin
			@(negedge i_sys_clk);
			if (get(s) !== v) bad = 1'b1;
		end
		`CHK(bad, 1'b0)
		@(posedge i_sys_clk);
	endtask : hold

	initial begin
		void'($urandom(32'h22bd770d));
		repeat (16) @(posedge i_sys_clk);
		`CHK({o_tone_tx, o_xmt_cut, o_receive_notch_filter}, 3'b111)
		i_rst_b <= 1'b1;
		wait_ms(5);
		i_tone_rx <= 1'b0;
		t0 = cyc;
		at(1, 1'b0, 50);
		at(0, 1'b0, 625);
		// Delay-dial wink, then start-dial
		busy <= 1'b1;
		t0 = cyc;
		at(0, 1'b1, 0);
		at(2, 1'b0, 20);
		at(0, 1'b0, 125);
		busy <= 1'b0;
		t0 = cyc;
		at(2, 1'b1, 20);
		at(0, 1'b0, 625);
		// Incoming dial train, pulse width drawn at random
		w = $urandom_range(60, 20);
		t0 = cyc;
		for (int p = 0; p < 3; p++) begin
			i_tone_rx <= 1'b1;
			wait_ms(7);
			if (p == 0) `CHK(o_xmt_cut, 1'b1)
			wait_ms(w - 7);
			i_tone_rx <= 1'b0;
			falls.push_back((cyc - t0) / T);
			if (p < 2) wait_ms(40);
		end
		last = falls[$];
		at(1, 1'b0, (last + 50 > 225) ? last + 50 : 225);
		t0 = t0 + last * T;
		at(0, 1'b0, 625);
		// Toll answer, then talking
		busy <= 1'b1;
		t0 = cyc;
		at(2, 1'b0, 20);
		at(0, 1'b0, 125);
		hold(3, 1'b0, 100);
		// Far disconnect, then local disconnect
		i_tone_rx <= 1'b1;
		t0 = cyc;
		at(1, 1'b1, 13);
		hold(0, 1'b0, 30);
		busy <= 1'b0;
		t0 = cyc;
		at(0, 1'b1, 0);
		at(2, 1'b1, 20);
		hold(0, 1'b1, 700);
		// Break stretch, long breaks and glitches while idle
		busy <= 1'b1;
		wait_ms(100);
		foreach (lens[i]) begin
			busy <= 1'b0;
			t0 = cyc;
			wait_ms(lens[i]);
			busy <= 1'b1;
			if (ext[i] == 0) hold(2, 1'b0, 60);
			else at(2, 1'b0, 20 + ext[i]);
			wait_ms(60);
		end
		busy <= 1'b0;
		wait_ms(100);
		busy <= 1'b1;
		t0 = cyc;
		at(2, 1'b0, 20);
		wait_ms(10);
		busy <= 1'b0;
		at(2, 1'b1, 50);
		// B-side after a second reset
		i_rst_b  <= 1'b0;
		i_side_b <= 1'b1;
		wait_ms(2);
		`CHK({o_tone_tx, o_xmt_cut, o_receive_notch_filter}, 3'b111)
		i_rst_b <= 1'b1;
		wait_ms(2);
		busy <= 1'b1;
		t0 = cyc;
		at(2, 1'b0, 20);
		i_tone_rx <= 1'b0;
		wait_ms(5);
		results();
	end
endmodule : sf_supervision_timing_tb_top

/* File: sim/sf_trunk_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Trunk circuit model driving the E&M leads
// ----------------------------------------------------------------
module sf_trunk_model (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_side_b,
	input  wire logic i_busy,
	output logic      o_m_lead,
	output logic      o_e_lead
);
	logic noise;

	// The unused lead wanders every cycle so the design cannot lean on it
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			noise <= 1'b0;
		end else begin
			noise <= ~noise;
		end
	end

	// A-side signals on M, B-side on E
	assign o_m_lead = i_side_b ? noise : i_busy;
	assign o_e_lead = i_side_b ? i_busy : noise;
endmodule : sf_trunk_model

/* File: src/sf_break_stretch.sv */
`timescale 1ns/1ns
// Minimum-break corrector on the transmitted tone
module sf_break_stretch #(
	parameter int         W      = 10,
	parameter logic [9:0] MIN_MS = sf_timing_pkg::MIN_BREAK_MS
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_ms_tick,
	input  wire logic i_tone_req,
	output logic      o_tone
);

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_tone;

	// ----------------------------------------------------------------
	// Stretch only tone intervals; tone-off winks pass untouched
	// ----------------------------------------------------------------
	always_comb begin
		next_cnt  = cnt;
		next_tone = o_tone;
		if (!o_tone && i_tone_req) begin
			next_tone = 1'b1;
			next_cnt  = W'(MIN_MS);
		end else if (o_tone) begin
			if (i_ms_tick && cnt != '0) begin
				next_cnt = cnt - W'(1);
			end
			// Long intervals end with the request itself
			if (!i_tone_req && cnt == '0) begin
				next_tone = 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt    <= '0;
			o_tone <= 1'b1;
		end else begin
			cnt    <= next_cnt;
			o_tone <= next_tone;
		end
	end

endmodule : sf_break_stretch

/* File: src/sf_lead_delay.sv */
`timescale 1ns/1ns
// Symmetrical delay: output follows input only after input is stable
module sf_lead_delay #(
	parameter int         W        = 10,
	parameter logic [9:0] DELAY_MS = sf_timing_pkg::LEAD_DELAY_MS
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_ms_tick,
	input  wire logic i_lead,
	output logic      o_lead
);

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_lead;

	// ----------------------------------------------------------------
	// Stability counter
	// ----------------------------------------------------------------
	// A change must persist the whole delay, so glitches are swallowed
	always_comb begin
		next_cnt  = cnt;
		next_lead = o_lead;
		if (i_lead == o_lead) begin
			next_cnt = '0;
		end else if (i_ms_tick) begin
			if (cnt == W'(DELAY_MS - 10'd1)) begin
				next_cnt  = '0;
				next_lead = i_lead;
			end else begin
				next_cnt = cnt + W'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt    <= '0;
			o_lead <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			o_lead <= next_lead;
		end
	end

endmodule : sf_lead_delay

/* File: src/sf_supervision_timing.sv */
`timescale 1ns/1ns
// Transmit-cut and receive notch timing for distant-originated calls
module sf_supervision_timing #(
	parameter int TICK_CYCLES = sf_timing_pkg::CYCLES_PER_MS
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_side_b,
	input  wire logic i_m_lead,
	input  wire logic i_e_lead,
	input  wire logic i_tone_rx,
	output logic      o_tone_tx,
	output logic      o_xmt_cut,
	output logic      o_receive_notch_filter,
	output logic      o_e_lead,
	output logic      o_m_lead
);

	localparam int TW     = sf_timing_pkg::TIMER_W;
	localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Count a timer down by one on each millisecond tick
	function automatic logic [TW-1:0] tick_down(input logic [TW-1:0] v, input logic t);
		if (t && v != '0) begin
			return v - TW'(1);
		end
		return v;
	endfunction : tick_down

	// Longer of a running timer and a new load, so no cut is shortened
	function automatic logic [TW-1:0] longer(input logic [TW-1:0] a, input logic [TW-1:0] b);
		return (a > b) ? a : b;
	endfunction : longer

	// ----------------------------------------------------------------
	// Millisecond time base
	// ----------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	logic              ms_tick;

	// Free-running, so every timed interval shares one reference
	always_comb begin
		ms_tick       = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
		next_tick_cnt = ms_tick ? '0 : tick_cnt + TICK_W'(1);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= next_tick_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Lead selection and edge detection
	// ----------------------------------------------------------------
	logic lead_in;
	logic lead_q;
	logic tone_q;
	logic lead_rise;
	logic lead_fall;
	logic tone_rise;
	logic tone_fall;
	logic lead_dly;
	logic tone_gate;

	// A-side takes the M lead, B-side the E lead; high means battery
	always_comb begin
		lead_in   = i_side_b ? i_e_lead : i_m_lead;
		lead_rise = lead_in & ~lead_q;
		lead_fall = ~lead_in & lead_q;
		tone_rise = i_tone_rx & ~tone_q;
		tone_fall = ~i_tone_rx & tone_q;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lead_q <= 1'b0;
			tone_q <= 1'b1;
		end else begin
			lead_q <= lead_in;
			tone_q <= i_tone_rx;
		end
	end

	// ----------------------------------------------------------------
	// Tone transmit path: delay then minimum-break correction
	// ----------------------------------------------------------------
	// The delay gives the cut below its head start over the tone change
	sf_lead_delay #(
		.W        (TW),
		.DELAY_MS (sf_timing_pkg::LEAD_DELAY_MS)
	) u_lead_delay (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_ms_tick (ms_tick),
		.i_lead    (lead_in),
		.o_lead    (lead_dly)
	);

	sf_break_stretch #(
		.W      (TW),
		.MIN_MS (sf_timing_pkg::MIN_BREAK_MS)
	) u_break_stretch (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_ms_tick  (ms_tick),
		.i_tone_req (~lead_dly),
		.o_tone     (tone_gate)
	);

	// ----------------------------------------------------------------
	// Precut on every lead change
	// ----------------------------------------------------------------
	logic precut;
	logic next_precut;

	// Any lead edge cuts the path until the delayed lead has caught up,
	// so states whose own timers leave the path open still get a precut;
	// a glitch that dies inside the delay lets the precut go again at once
	always_comb begin
		next_precut = precut;
		if (lead_rise || lead_fall) begin
			next_precut = 1'b1;
		end else if (lead_dly == lead_in) begin
			next_precut = 1'b0;
		end
	end

	// Reset leaves no precut pending; idle already holds the path cut
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			precut <= 1'b0;
		end else begin
			precut <= next_precut;
		end
	end

	// ----------------------------------------------------------------
	// Call state and timers
	// ----------------------------------------------------------------
	sf_timing_pkg::call_state_t state;
	sf_timing_pkg::call_state_t next_state;
	logic [TW-1:0] cut_cnt;
	logic [TW-1:0] next_cut_cnt;
	logic [TW-1:0] ins_cnt;
	logic [TW-1:0] next_ins_cnt;
	logic [TW-1:0] rm_cnt;
	logic [TW-1:0] next_rm_cnt;
	logic [TW-1:0] min_cnt;
	logic [TW-1:0] next_min_cnt;
	logic          rm_pend;
	logic          next_rm_pend;
	logic          cut_hold;
	logic          next_cut_hold;
	logic          notch;
	logic          next_notch;

	// Edges on the received tone and the raw lead drive every interval
	always_comb begin
		next_state    = state;
		next_cut_cnt  = tick_down(cut_cnt, ms_tick);
		next_ins_cnt  = tick_down(ins_cnt, ms_tick);
		next_rm_cnt   = tick_down(rm_cnt, ms_tick);
		next_min_cnt  = tick_down(min_cnt, ms_tick);
		next_rm_pend  = rm_pend;
		next_cut_hold = cut_hold;
		next_notch    = notch;
		case (state)
			sf_timing_pkg::ST_IDLE: begin
				if (tone_fall) begin
					// Distant seizure
					next_state    = sf_timing_pkg::ST_SEIZE;
					next_cut_hold = 1'b0;
					next_cut_cnt  = sf_timing_pkg::SEIZE_CUT_MS;
					next_rm_cnt   = sf_timing_pkg::NOTCH_REMOVE_MS;
					next_rm_pend  = 1'b1;
					next_ins_cnt  = '0;
				end else if (tone_rise) begin
					// Far end goes on-hook after a local disconnect
					next_ins_cnt = sf_timing_pkg::NOTCH_INSERT_MS;
					next_rm_pend = 1'b0;
				end
			end
			sf_timing_pkg::ST_SEIZE: begin
				if (tone_rise) begin
					// First incoming dial pulse: cut at once
					next_state   = sf_timing_pkg::ST_DIAL;
					next_cut_cnt = sf_timing_pkg::DIAL_CUT_MS;
					next_ins_cnt = sf_timing_pkg::NOTCH_INSERT_MS;
					next_min_cnt = sf_timing_pkg::NOTCH_MIN_MS;
					next_rm_pend = 1'b0;
				end else if (lead_rise) begin
					// Delay-dial wink begins
					next_cut_cnt = longer(next_cut_cnt, sf_timing_pkg::ANSWER_CUT_MS);
				end else if (lead_fall) begin
					// Start-dial: tone resumes after the lead delay
					next_cut_cnt = longer(next_cut_cnt,
						sf_timing_pkg::START_DIAL_CUT_MS);
				end
			end
			sf_timing_pkg::ST_DIAL: begin
				if (tone_rise || tone_fall) begin
					// Every break or make restarts the quiet period
					next_cut_cnt = sf_timing_pkg::DIAL_CUT_MS;
				end
				if (tone_rise) begin
					next_rm_pend = 1'b0;
				end else if (tone_fall) begin
					next_rm_cnt  = sf_timing_pkg::NOTCH_REMOVE_MS;
					next_rm_pend = 1'b1;
				end
				if (lead_rise) begin
					// Answer from the local end
					next_state   = sf_timing_pkg::ST_TALK;
					next_cut_cnt = longer(next_cut_cnt, sf_timing_pkg::ANSWER_CUT_MS);
				end
			end
			sf_timing_pkg::ST_TALK: begin
				if (tone_rise) begin
					// Distant disconnect: filter only, path left as is
					next_ins_cnt = sf_timing_pkg::NOTCH_INSERT_MS;
					next_rm_pend = 1'b0;
				end else if (tone_fall) begin
					next_rm_cnt  = sf_timing_pkg::NOTCH_REMOVE_MS;
					next_rm_pend = 1'b1;
				end
				if (lead_fall) begin
					// Local disconnect: cut now, tone follows the delay
					next_state    = sf_timing_pkg::ST_IDLE;
					next_cut_hold = 1'b1;
				end
			end
			default: begin
				next_state    = sf_timing_pkg::ST_IDLE;
				next_cut_hold = 1'b1;
			end
		endcase
		// Filter insertion and removal; nothing moves without a pending timer
		if (ins_cnt == TW'(1) && ms_tick) begin
			next_notch = 1'b1;
		end else if (rm_pend && rm_cnt == '0 && min_cnt == '0 && !i_tone_rx) begin
			next_notch   = 1'b0;
			next_rm_pend = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state    <= sf_timing_pkg::ST_IDLE;
			cut_cnt  <= '0;
			ins_cnt  <= '0;
			rm_cnt   <= '0;
			min_cnt  <= '0;
			rm_pend  <= 1'b0;
			cut_hold <= 1'b1;
			notch    <= 1'b1;
		end else begin
			state    <= next_state;
			cut_cnt  <= next_cut_cnt;
			ins_cnt  <= next_ins_cnt;
			rm_cnt   <= next_rm_cnt;
			min_cnt  <= next_min_cnt;
			rm_pend  <= next_rm_pend;
			cut_hold <= next_cut_hold;
			notch    <= next_notch;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	logic next_xmt_cut;
	logic next_out_busy;

	// Output lead signals busy while the distant end holds tone off
	always_comb begin
		next_xmt_cut  = next_cut_hold || (next_cut_cnt != '0) || next_precut;
		next_out_busy = ~i_tone_rx;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_xmt_cut              <= 1'b1;
			o_receive_notch_filter <= 1'b1;
			o_tone_tx              <= 1'b1;
			o_e_lead               <= 1'b0;
			o_m_lead               <= 1'b0;
		end else begin
			o_xmt_cut              <= next_xmt_cut;
			o_receive_notch_filter <= next_notch;
			o_tone_tx              <= tone_gate;
			o_e_lead               <= ~i_side_b & next_out_busy;
			o_m_lead               <= i_side_b & next_out_busy;
		end
	end

endmodule : sf_supervision_timing
